//--- src/ctc_pkg.sv
package ctc_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_NS = 8;
   localparam int unsigned TICK_NS = 1000000;
   localparam int unsigned TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [15:0] DEB_MS = 16'h0014;
   localparam logic [15:0] HOLD_MIN_MS = 16'h07D0;
   localparam logic [15:0] HOLD_MAX_MS = 16'h2328;
   localparam logic [15:0] HOLD_LONG_MS = 16'h2710;
   localparam logic [15:0] BLANK_MS = 16'h01F4;
   localparam logic [15:0] FAIL_MS = 16'h03E8;
   localparam logic [15:0] FLASH_HALF_MS = 16'h0032;
   localparam logic [15:0] ACK_MS = 16'h0064;
   localparam logic [15:0] IOL_PERIOD_MS = 16'h03E8;
   localparam logic [15:0] IOL_GAP_MS = 16'h0032;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_RESERVE = 8'h04;
   localparam logic [7:0] OFS_THRESH = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   localparam logic [7:0] OFS_MON = 8'h18;
   localparam logic [7:0] OFS_RANGE = 8'h1C;

   localparam int unsigned CTRL_IOL = 0;
   localparam int unsigned CTRL_INV = 1;
   localparam int unsigned CTRL_LOCK = 2;
   localparam int unsigned CTRL_TFULL = 4;
   localparam int unsigned CTRL_TEMPTY = 5;
   localparam int unsigned CTRL_FRST = 6;

   localparam int unsigned IRQ_OK = 0;
   localparam int unsigned IRQ_FAIL = 1;
   localparam int unsigned IRQ_VMON = 2;
   localparam int unsigned IRQ_TMON = 3;
   localparam int unsigned IRQ_PRESS = 4;
   localparam int unsigned IRQ_W = 5;

   // ---------------------------------------------------------------
   // Reset values and limits
   // ---------------------------------------------------------------
   localparam logic [7:0] RESERVE_RST = 8'h14;
   localparam logic [15:0] FACT_TH = 16'h0800;
   localparam logic [15:0] RANGE_MIN_RST = 16'h0040;
   localparam logic [15:0] RANGE_MAX_RST = 16'hF000;
   localparam logic [11:0] VMON_MIN = 12'h200;
   localparam logic [11:0] VMON_MAX = 12'hE00;
   localparam logic [11:0] TMON_MAX = 12'hC00;
   localparam logic [31:0] PCT_DIV = 32'h0000_0064;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic green;
      logic yellow;
   } ctc_led_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } ctc_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } ctc_apb_rsp_t;

   typedef enum logic [2:0] {
      ACT_NONE, ACT_FULL, ACT_EMPTY, ACT_INVERT, ACT_FACTORY, ACT_FAIL
   } ctc_act_t;

   typedef enum logic [1:0] {LS_RUN, LS_BLANK, LS_FAIL} ctc_led_st_t;

endpackage : ctc_pkg

//--- src/ctc_top.sv
// Functional notes
// - Full teach: threshold below captured capacitance
// - Empty teach: threshold above captured capacitance
// - Both taught: threshold midway between captures
// - Full and empty teach, any gap between
// - Safety reserve automatic, settable over IO-Link
// - Yellow actuated, green idle, press flash
// - Successful teach blanks LED half second
// - Failed teach flashes green one second
// - Return to normal after teach automatically
// - IO-Link mode: green with short gaps
// - Factory state: normally open, nominal distance
// - Configure via IO-Link, button, teach wire
// - One line: IO-Link or switching output
// - Supply voltage and temperature monitored internally
// - Out-of-range threshold rejected, settings kept
// - Reserve twenty percent below or above
// - Over ten seconds: invert or factory reset
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none

module ctc_top #(
   parameter int unsigned TICK_CYCLES = ctc_pkg::TICK_CYC,
   parameter int unsigned CW = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // APB slave
   input wire ctc_pkg::ctc_apb_req_t apb_req,
   output ctc_pkg::ctc_apb_rsp_t apb_rsp,
   // Measurement and monitors
   input wire logic [CW-1:0] cap_value,
   input wire logic [11:0] vmon_value,
   input wire logic [11:0] tmon_value,
   // Local controls (asynchronous pins)
   input wire logic button_full,
   input wire logic button_empty,
   input wire logic wire_at_supply,
   input wire logic wire_at_ground,
   // IO-Link transceiver side
   input wire logic iol_tx_data,
   input wire logic iol_tx_en,
   output logic iol_rx_data,
   // Shared output line
   input wire logic line_i,
   output logic line_o,
   output logic line_oe,
   // Indicator and interrupt
   output ctc_pkg::ctc_led_t led,
   output logic irq
);
   import ctc_pkg::*;

   // ---------------------------------------------------------------
   // Millisecond tick
   // ---------------------------------------------------------------
   logic [31:0] div_q;
   logic tick;
   assign tick = (div_q == TICK_CYCLES - 1);
   always_ff @(posedge clk) begin
      if (rst || tick) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 32'h0000_0001;
      end
   end

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [4:0] sync1_q, sync2_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= {line_i, wire_at_ground, button_empty,
                     wire_at_supply, button_full};
         sync2_q <= sync1_q;
      end
   end

   // ---------------------------------------------------------------
   // Debounce and hold timing, channel 0 full, channel 1 empty
   // ---------------------------------------------------------------
   logic [1:0] raw, deb_q, press;
   logic [15:0] stab_q [2];
   logic [15:0] hold_q [2];
   ctc_act_t local_act;
   logic lock_q;
   assign raw[0] = (sync2_q[0] | sync2_q[1]) & ~lock_q;
   assign raw[1] = (sync2_q[2] | sync2_q[3]) & ~lock_q;
   assign press = raw & ~deb_q & {2{tick}} &
                  {stab_q[1] >= DEB_MS - 16'h0001,
                   stab_q[0] >= DEB_MS - 16'h0001};

   always_ff @(posedge clk) begin
      if (rst) begin
         deb_q <= '0;
         for (int c = 0; c < 2; c++) begin
            stab_q[c] <= '0;
            hold_q[c] <= '0;
         end
      end else if (tick) begin
         for (int c = 0; c < 2; c++) begin
            if (raw[c] == deb_q[c]) begin
               stab_q[c] <= '0;
            end else if (stab_q[c] >= DEB_MS - 16'h0001) begin
               stab_q[c] <= '0;
               deb_q[c] <= raw[c];
            end else begin
               stab_q[c] <= stab_q[c] + 16'h0001;
            end
            if (!deb_q[c]) begin
               hold_q[c] <= '0;
            end else if (hold_q[c] != 16'hFFFF) begin
               hold_q[c] <= hold_q[c] + 16'h0001;
            end
         end
      end
   end

   // Decoded on release only
   always_comb begin
      local_act = ACT_NONE;
      for (int c = 0; c < 2; c++) begin
         if (tick && deb_q[c] && !raw[c] &&
             stab_q[c] >= DEB_MS - 16'h0001) begin
            if (hold_q[c] > HOLD_LONG_MS) begin
               local_act = (c == 0) ? ACT_INVERT : ACT_FACTORY;
            end else if (hold_q[c] >= HOLD_MIN_MS &&
                         hold_q[c] <= HOLD_MAX_MS) begin
               local_act = (c == 0) ? ACT_FULL : ACT_EMPTY;
            end else begin
               local_act = ACT_FAIL;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // APB decode
   // ---------------------------------------------------------------
   logic wr_en, rd_setup;
   assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite &
                  apb_rsp.pready;
   assign rd_setup = apb_req.psel & ~apb_req.penable;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction : hit

   // ---------------------------------------------------------------
   // Action selection and threshold computation
   // ---------------------------------------------------------------
   ctc_act_t act;
   logic iol_q, inv_q;
   logic [7:0] reserve_q;
   logic [15:0] rmin_q, rmax_q;
   logic [CW-1:0] th_q, fcap_q, ecap_q;
   logic fval_q, eval_q;
   logic [31:0] new_th;
   logic th_ok;

   always_comb begin
      act = local_act;
      if (wr_en && hit(apb_req.paddr, OFS_CTRL)) begin
         if (apb_req.pwdata[CTRL_FRST]) begin
            act = ACT_FACTORY;
         end else if (apb_req.pwdata[CTRL_TFULL]) begin
            act = ACT_FULL;
         end else if (apb_req.pwdata[CTRL_TEMPTY]) begin
            act = ACT_EMPTY;
         end
      end
   end

   function automatic logic [31:0] pct(input logic [CW-1:0] c,
                                       input logic [7:0] r);
      pct = (32'(c) * 32'(r)) / PCT_DIV;
   endfunction : pct

   always_comb begin
      new_th = 32'(th_q);
      if (act == ACT_FULL) begin
         if (eval_q) begin
            new_th = (32'(cap_value) + 32'(ecap_q)) >> 1;
         end else if (pct(cap_value, reserve_q) > 32'(cap_value)) begin
            new_th = '0;
         end else begin
            new_th = 32'(cap_value) - pct(cap_value, reserve_q);
         end
      end else if (act == ACT_EMPTY) begin
         if (fval_q) begin
            new_th = (32'(fcap_q) + 32'(cap_value)) >> 1;
         end else begin
            new_th = 32'(cap_value) + pct(cap_value, reserve_q);
         end
      end
      th_ok = (new_th >= 32'(rmin_q)) && (new_th <= 32'(rmax_q));
   end

   // ---------------------------------------------------------------
   // Configuration registers
   // ---------------------------------------------------------------
   logic teach_ok_ev, teach_fail_ev;
   assign teach_ok_ev = (act == ACT_INVERT) || (act == ACT_FACTORY) ||
                        (((act == ACT_FULL) || (act == ACT_EMPTY)) && th_ok);
   assign teach_fail_ev = (act == ACT_FAIL) ||
                          (((act == ACT_FULL) || (act == ACT_EMPTY)) && !th_ok);

   always_ff @(posedge clk) begin
      if (rst || act == ACT_FACTORY) begin
         th_q <= CW'(FACT_TH);
         inv_q <= 1'b0;
         fval_q <= 1'b0;
         eval_q <= 1'b0;
         fcap_q <= '0;
         ecap_q <= '0;
         if (rst) begin
            iol_q <= 1'b0;
            lock_q <= 1'b0;
            reserve_q <= RESERVE_RST;
            rmin_q <= RANGE_MIN_RST;
            rmax_q <= RANGE_MAX_RST;
         end
      end else begin
         if (act == ACT_INVERT) begin
            inv_q <= ~inv_q;
         end
         if (act == ACT_FULL && th_ok) begin
            th_q <= new_th[CW-1:0];
            fcap_q <= cap_value;
            fval_q <= 1'b1;
         end
         if (act == ACT_EMPTY && th_ok) begin
            th_q <= new_th[CW-1:0];
            ecap_q <= cap_value;
            eval_q <= 1'b1;
         end
         if (wr_en && hit(apb_req.paddr, OFS_CTRL)) begin
            iol_q <= apb_req.pwdata[CTRL_IOL];
            lock_q <= apb_req.pwdata[CTRL_LOCK];
            if (act == ACT_NONE) begin
               inv_q <= apb_req.pwdata[CTRL_INV];
            end
         end else if (wr_en && hit(apb_req.paddr, OFS_RESERVE)) begin
            reserve_q <= apb_req.pwdata[7:0];
         end else if (wr_en && hit(apb_req.paddr, OFS_RANGE)) begin
            rmin_q <= apb_req.pwdata[15:0];
            rmax_q <= apb_req.pwdata[31:16];
         end
      end
   end

   // ---------------------------------------------------------------
   // Switching and shared line
   // ---------------------------------------------------------------
   logic actuated_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         actuated_q <= 1'b0;
         line_o <= 1'b0;
         line_oe <= 1'b0;
         iol_rx_data <= 1'b0;
      end else begin
         actuated_q <= (cap_value >= th_q);
         iol_rx_data <= sync2_q[4];
         if (iol_q) begin
            line_o <= iol_tx_data;
            line_oe <= iol_tx_en;
         end else begin
            line_o <= actuated_q ^ inv_q;
            line_oe <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Indicator sequencing
   // ---------------------------------------------------------------
   ctc_led_st_t ls_q;
   logic [15:0] lt_q, ack_q, iolc_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         ls_q <= LS_RUN;
         lt_q <= '0;
      end else if (teach_ok_ev) begin
         ls_q <= LS_BLANK;
         lt_q <= '0;
      end else if (teach_fail_ev) begin
         ls_q <= LS_FAIL;
         lt_q <= '0;
      end else if (tick) begin
         lt_q <= lt_q + 16'h0001;
         case (ls_q)
            LS_BLANK: begin
               if (lt_q >= BLANK_MS - 16'h0001) begin
                  ls_q <= LS_RUN;
               end
            end
            LS_FAIL: begin
               if (lt_q >= FAIL_MS - 16'h0001) begin
                  ls_q <= LS_RUN;
               end
            end
            default: begin
               lt_q <= '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ack_q <= '0;
         iolc_q <= '0;
      end else begin
         if (|press) begin
            ack_q <= ACK_MS;
         end else if (tick && ack_q != 16'h0000) begin
            ack_q <= ack_q - 16'h0001;
         end
         if (tick) begin
            iolc_q <= (iolc_q >= IOL_PERIOD_MS - 16'h0001) ? 16'h0000 :
                      iolc_q + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         led <= '0;
      end else begin
         case (ls_q)
            LS_BLANK: begin
               led <= '0;
            end
            LS_FAIL: begin
               led.yellow <= 1'b0;
               led.green <= ((lt_q / FLASH_HALF_MS) & 16'h0001) == 16'h0000;
            end
            default: begin
               if (ack_q != 16'h0000) begin
                  led <= '{green: 1'b1, yellow: 1'b1};
               end else if (iol_q) begin
                  led.yellow <= 1'b0;
                  led.green <= (iolc_q >= IOL_GAP_MS);
               end else begin
                  led.yellow <= actuated_q;
                  led.green <= ~actuated_q;
               end
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Interrupt status, write one to clear, set wins
   // ---------------------------------------------------------------
   logic [IRQ_W-1:0] ist_q, imask_q, iev, iclr;
   assign iev[IRQ_OK] = teach_ok_ev;
   assign iev[IRQ_FAIL] = teach_fail_ev;
   assign iev[IRQ_VMON] = (vmon_value < VMON_MIN) ||
                          (vmon_value > VMON_MAX);
   assign iev[IRQ_TMON] = (tmon_value > TMON_MAX);
   assign iev[IRQ_PRESS] = |press;
   assign iclr = (wr_en && hit(apb_req.paddr, OFS_IRQ_STAT)) ?
                 apb_req.pwdata[IRQ_W-1:0] : '0;

   always_ff @(posedge clk) begin
      if (rst) begin
         ist_q <= '0;
         imask_q <= '0;
         irq <= 1'b0;
      end else begin
         ist_q <= (ist_q & ~iclr) | iev;
         if (wr_en && hit(apb_req.paddr, OFS_IRQ_MASK)) begin
            imask_q <= apb_req.pwdata[IRQ_W-1:0];
         end
         irq <= |(ist_q & imask_q);
      end
   end

   // ---------------------------------------------------------------
   // APB response, one access cycle, data from setup cycle
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         apb_rsp <= '0;
      end else begin
         apb_rsp.pready <= rd_setup;
         apb_rsp.pslverr <= 1'b0;
         apb_rsp.prdata <= '0;
         if (rd_setup) begin
            if (hit(apb_req.paddr, OFS_CTRL)) begin
               apb_rsp.prdata <= {29'h0, lock_q, inv_q, iol_q};
            end else if (hit(apb_req.paddr, OFS_RESERVE)) begin
               apb_rsp.prdata <= {24'h0, reserve_q};
            end else if (hit(apb_req.paddr, OFS_THRESH)) begin
               apb_rsp.prdata <= 32'(th_q);
            end else if (hit(apb_req.paddr, OFS_STATUS)) begin
               apb_rsp.prdata <= {26'h0, ls_q, deb_q, actuated_q,
                                  fval_q & eval_q};
            end else if (hit(apb_req.paddr, OFS_IRQ_STAT)) begin
               apb_rsp.prdata <= 32'(ist_q);
            end else if (hit(apb_req.paddr, OFS_IRQ_MASK)) begin
               apb_rsp.prdata <= 32'(imask_q);
            end else if (hit(apb_req.paddr, OFS_MON)) begin
               apb_rsp.prdata <= {4'h0, tmon_value, 4'h0, vmon_value};
            end else if (hit(apb_req.paddr, OFS_RANGE)) begin
               apb_rsp.prdata <= {rmax_q, rmin_q};
            end else begin
               apb_rsp.pslverr <= 1'b1;
            end
         end
      end
   end

endmodule : ctc_top

`default_nettype wire

//--- test/ctc_top_props.sv
`timescale 1ns/10ps
`default_nettype none
module ctc_top_props #(
   parameter int unsigned TICK_CYCLES = ctc_pkg::TICK_CYC,
   parameter int unsigned CW = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // APB
   input wire ctc_pkg::ctc_apb_req_t apb_req,
   input wire ctc_pkg::ctc_apb_rsp_t apb_rsp,
   // Line, indicator, interrupt
   input wire logic line_i,
   input wire logic line_o,
   input wire logic line_oe,
   input wire logic iol_rx_data,
   input wire ctc_pkg::ctc_led_t led,
   input wire logic irq
);
   import ctc_pkg::*;
   // ---------------------------------------------------------------
   // Dark time counter
   // ---------------------------------------------------------------
   localparam logic [31:0] DARK_MAX = (32'(BLANK_MS) + 32'h4) * TICK_CYCLES;
   logic [31:0] dark_q;
   logic apb_wr;
   assign apb_wr = apb_req.psel & apb_req.penable & apb_req.pwrite
                   & apb_rsp.pready;
   always_ff @(posedge clk) begin
      if (rst || led != 2'b00) begin
         dark_q <= '0;
      end else begin
         dark_q <= dark_q + 32'h1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   chk_apb_answer: assert property (
      apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
      else $error("pready missing after setup");
   chk_ready_pulse: assert property (
      apb_rsp.pready |=> !apb_rsp.pready)
      else $error("pready held too long");
   chk_err_no_data: assert property (
      apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0)
      else $error("error response carries data");
   chk_unmapped_err: assert property (
      apb_req.psel && apb_req.penable && apb_rsp.pready
      && apb_req.paddr > OFS_RANGE |-> apb_rsp.pslverr)
      else $error("unmapped access not refused");
   chk_rx_follow: assert property (
      !$past(rst) && !$past(rst, 2) && !$past(rst, 3)
      |-> iol_rx_data == $past(line_i, 3))
      else $error("receive data does not follow line");
   chk_reset_quiet: assert property (@(posedge clk) disable iff (1'b0)
      rst |=> led == 2'b00 && !line_oe && !irq && !apb_rsp.pready)
      else $error("outputs active in reset");
   chk_oe_release: assert property (
      $fell(rst) |-> ##[1:3] line_oe)
      else $error("switching output not driven after reset");
   chk_dark_bound: assert property (
      dark_q < DARK_MAX)
      else $error("indicator dark too long");
   chk_irq_clear: assert property (
      $fell(irq) |-> $past(apb_wr) || $past(apb_wr, 2) || $past(apb_wr, 3))
      else $error("interrupt dropped without a write");
endmodule : ctc_top_props
bind ctc_top ctc_top_props #(.TICK_CYCLES(TICK_CYCLES), .CW(CW)) u_props (
   .clk(clk), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
   .line_i(line_i), .line_o(line_o), .line_oe(line_oe),
   .iol_rx_data(iol_rx_data), .led(led), .irq(irq));
`default_nettype wire

//--- test/ctc_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module ctc_far_model (
   // Clock
   input wire logic clk,
   // Shared line
   input wire logic line_o,
   input wire logic line_oe,
   output logic line_i,
   // Local controls
   output logic button_full,
   output logic button_empty,
   output logic wire_at_supply,
   output logic wire_at_ground
);
   logic mst_en = 1'b0;
   logic mst_lvl = 1'b0;
   initial begin
      {button_full, button_empty, wire_at_supply, wire_at_ground} = 4'h0;
   end
   // Device, else master, else pull-down
   assign line_i = line_oe ? line_o : (mst_en ? mst_lvl : 1'b0);
   task hold(input int ch, input int cyc);
      @(posedge clk);
      case (ch)
         0: button_full <= 1'b1;
         1: button_empty <= 1'b1;
         2: wire_at_supply <= 1'b1;
         default: wire_at_ground <= 1'b1;
      endcase
      repeat (cyc) @(posedge clk);
      {button_full, button_empty, wire_at_supply, wire_at_ground} <= 4'h0;
   endtask : hold
   task talk(input logic en, input logic lvl);
      @(posedge clk);
      mst_en <= en;
      mst_lvl <= lvl;
   endtask : talk
endmodule : ctc_far_model
`default_nettype wire

//--- test/capacitive_teach_controller_bench.sv
`timescale 1ns/10ps
`default_nettype none
module capacitive_teach_controller_bench;
   import ctc_pkg::*;
   localparam int TK = 2;
   logic clk = 1'b0;
   logic rst = 1'b1;
   ctc_apb_req_t req = '0;
   ctc_apb_rsp_t rsp;
   logic [15:0] cap = 16'h0700;
   logic [11:0] vmon = 12'h800;
   logic [11:0] tmon = 12'h400;
   logic txd = 1'b0;
   logic txe = 1'b0;
   logic rxd, li, lo, loe, irq, bf, be, ws, wg, e;
   ctc_led_t led;
   logic [31:0] q;
   int mismatches = 0;
   int cmp_count = 0;
   int cyc = 0;
   always #4 clk = ~clk;
   ctc_top #(.TICK_CYCLES(TK)) u_ctc_top (.clk(clk), .rst(rst),
      .apb_req(req), .apb_rsp(rsp), .cap_value(cap), .vmon_value(vmon),
      .tmon_value(tmon), .button_full(bf), .button_empty(be),
      .wire_at_supply(ws), .wire_at_ground(wg), .iol_tx_data(txd),
      .iol_tx_en(txe), .iol_rx_data(rxd), .line_i(li), .line_o(lo),
      .line_oe(loe), .led(led), .irq(irq));
   ctc_far_model u_ctc_far_model (.clk(clk), .line_o(lo), .line_oe(loe),
      .line_i(li), .button_full(bf), .button_empty(be),
      .wire_at_supply(ws), .wire_at_ground(wg));
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task end_of_test;
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_of_test
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge clk);
      req.penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (rsp.pready !== 1'b1);
      q = rsp.prdata;
      e = rsp.pslverr;
      req <= '0;
      @(posedge clk);
   endtask : apb
   task rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(q, exp);
   endtask : rd
   task blank_ok;
      int n;
      n = 0;
      while (led !== 2'b00 && n < 100 * TK) begin
         @(posedge clk);
         n++;
      end
      check(32'(led), 32'h0);
      n = 0;
      while (led === 2'b00 && n < 600 * TK) begin
         @(posedge clk);
         n++;
      end
      check(32'(n > 490 * TK && n < 510 * TK), 32'h1);
   endtask : blank_ok
   task watch(input int n);
      logic g0, g1, y;
      {g0, g1, y} = 3'b000;
      repeat (n) begin
         @(posedge clk);
         g0 |= !led.green;
         g1 |= led.green;
         y |= led.yellow;
      end
      check(32'({g0, g1, y}), 32'h6);
   endtask : watch
   always @(posedge clk) begin
      cyc++;
      if (cyc == 80000) begin
         mismatches++;
         end_of_test();
      end
   end
   // ---------------------------------------------------------------
   // Sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(OFS_THRESH, 32'h0800);
      rd(OFS_RESERVE, 32'h14);
      apb(1'b0, 8'h20, 32'h0);
      check({q[30:0], e}, 32'h1);
      apb(1'b1, OFS_THRESH, 32'h1234);
      rd(OFS_THRESH, 32'h0800);
      repeat (8) @(posedge clk);
      check(32'({lo, loe, led}), 32'h6);
      cap <= 16'h0900;
      repeat (8) @(posedge clk);
      check(32'({lo, loe, led}), 32'hD);
      apb(1'b1, OFS_IRQ_MASK, 32'h3);
      cap <= 16'h1000;
      apb(1'b1, OFS_CTRL, 32'h10);
      blank_ok();
      rd(OFS_THRESH, 32'h0CCD);
      rd(OFS_IRQ_STAT, 32'h1);
      check(32'(irq), 32'h1);
      apb(1'b1, OFS_IRQ_STAT, 32'h1);
      repeat (3) @(posedge clk);
      check(32'(irq), 32'h0);
      cap <= 16'h0400;
      apb(1'b1, OFS_CTRL, 32'h20);
      blank_ok();
      rd(OFS_THRESH, 32'h0A00);
      apb(1'b1, OFS_CTRL, 32'h40);
      blank_ok();
      rd(OFS_THRESH, 32'h0800);
      apb(1'b1, OFS_RESERVE, 32'hA);
      cap <= 16'h1000;
      apb(1'b1, OFS_CTRL, 32'h20);
      blank_ok();
      rd(OFS_THRESH, 32'h1199);
      cap <= 16'hE000;
      apb(1'b1, OFS_CTRL, 32'h20);
      watch(900 * TK);
      repeat (200 * TK) @(posedge clk);
      rd(OFS_THRESH, 32'h1199);
      rd(OFS_IRQ_STAT, 32'h3);
      apb(1'b1, OFS_IRQ_STAT, 32'h3);
      cap <= 16'h0400;
      u_ctc_far_model.hold(0, 10100 * TK);
      blank_ok();
      check(32'({lo, led}), 32'h6);
      rd(OFS_IRQ_STAT, 32'h11);
      apb(1'b1, OFS_IRQ_STAT, 32'h1F);
      u_ctc_far_model.hold(3, 3000 * TK);
      blank_ok();
      rd(OFS_THRESH, 32'h0466);
      apb(1'b1, OFS_IRQ_STAT, 32'h1F);
      u_ctc_far_model.hold(1, 500 * TK);
      repeat (100) @(posedge clk);
      rd(OFS_IRQ_STAT, 32'h12);
      rd(OFS_THRESH, 32'h0466);
      repeat (1000 * TK) @(posedge clk);
      apb(1'b1, OFS_IRQ_STAT, 32'h1F);
      vmon <= 12'h100;
      tmon <= 12'hD00;
      repeat (4) @(posedge clk);
      rd(OFS_MON, 32'h0D00_0100);
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      check(32'({q[3:2], irq}), 32'h6);
      vmon <= 12'h800;
      tmon <= 12'h400;
      apb(1'b1, OFS_CTRL, 32'h1);
      watch(1100 * TK);
      txe <= 1'b1;
      txd <= 1'b1;
      repeat (4) @(posedge clk);
      check(32'({lo, loe}), 32'h3);
      txe <= 1'b0;
      u_ctc_far_model.talk(1'b1, 1'b1);
      repeat (8) @(posedge clk);
      check(32'({loe, rxd}), 32'h1);
      end_of_test();
   end
endmodule : capacitive_teach_controller_bench
`default_nettype wire
